// *** src/gpio_defs.svh ***
/*
  Register offsets, field positions, reset values and timing counts of the
  four-port GPIO block with external pin interrupts.
  Assumes a byte-addressed AXI4-Lite register window of 256 bytes.
*/
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define AXI_ADDR_W 8

`define REG_PORT_A_OUT 8'h00
`define REG_PORT_A_DIR 8'h04
`define REG_PORT_A_PINS 8'h08
`define REG_PORT_B_OUT 8'h10
`define REG_PORT_B_DIR 8'h14
`define REG_PORT_B_PINS 8'h18
`define REG_PORT_C_OUT 8'h20
`define REG_PORT_C_DIR 8'h24
`define REG_PORT_C_PINS 8'h28
`define REG_PORT_D_OUT 8'h30
`define REG_PORT_D_DIR 8'h34
`define REG_PORT_D_PINS 8'h38
`define REG_CORE_CONTROL 8'h40
`define REG_IRQ_STATUS 8'h44
`define REG_IRQ_MASK 8'h48
`define REG_IRQ_LEVEL 8'h4C

`define OUT_RESET 8'h00
`define DIR_RESET 8'h00
`define CTRL_RESET 8'h00
`define FLAG_RESET 8'h00
`define MASK_RESET 8'h00

`define SENSE_ZERO_LSB 0
`define SENSE_ONE_LSB 2
`define ASYNC_SELECT_BIT 6
`define FLAG_ASYNC_BIT 5
`define FLAG_ZERO_BIT 6
`define FLAG_ONE_BIT 7
`define FLAG_FIELD 8'hE0
`define CTRL_FIELD 8'h4F
`define WAKE_STATUS_BIT 0

`define PIN_IRQ_ZERO 26
`define PIN_IRQ_ONE 27
`define PIN_IRQ_ASYNC 10

`define SENSE_LOW 2'h0
`define SENSE_ANY 2'h1
`define SENSE_FALL 2'h2
`define SENSE_RISE 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define MCLK_PERIOD_NS 40
`define WDT_PERIOD_NS 1000
`define WDT_CYCLES ((`WDT_PERIOD_NS) / (`MCLK_PERIOD_NS))
`define WDT_CNT_W 5
`define WAKE_SAMPLES 2
`define SYNC_SETTLE 2'h3

`endif

// *** src/gpio_pkg.sv ***
/*
  Types shared by the GPIO block: pin drive bundle, sense field and the
  wake sequencer states.
  Assumes gpio_defs.svh for all numeric constants.
*/
package gpio_pkg;

  typedef logic [1:0] sense_t;

  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
    logic [31:0] pull_up;
  } pin_drive_t;

  typedef enum logic [1:0] {
    WAKE_AWAKE,
    WAKE_QUALIFY,
    WAKE_STARTUP
  } wake_state_t;

endpackage

// *** src/pin_sync.sv ***
/*
  Two-flop synchroniser for the 32 port pins.
  Assumes pins change asynchronously to mclk; only the second stage is read.
*/
`timescale 1ns/100ps

module pin_sync (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_sync_out
);

  typedef struct packed {
    logic [31:0] stage_one;
    logic [31:0] stage_two;
  } sync_state_t;

  sync_state_t q;
  sync_state_t next_q;

  always_comb begin
    next_q.stage_one = pin_in;
    next_q.stage_two = q.stage_one;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign pin_sync_out = q.stage_two;

endmodule

// *** src/gpio_ports.sv ***
/*
  Four 8-bit general-purpose ports with three external pin interrupts,
  reached over an AXI4-Lite slave.
  Assumes one clock (mclk) that stands for the I/O clock; io_clk_run, deep_sleep,
  startup_done and service_ack come from same-clock core logic. Pins are
  asynchronous and pass the two-flop synchroniser before any use.
  Edge detectors stay blind until the synchroniser holds real levels.
*/
// Added by the designer: the register addresses and the AXI4-Lite slave port.
// Functional notes
// - Four RW output data registers, reset zero
// - Four RW direction registers, reset all inputs
// - Read-only pin level registers, writes ignored
// - Interrupts sense pins even when outputs
// - Pins zero/one edge or level; async edge
// - Level mode requests while pin stays low
// - Edge detection needs running I/O clock
// - Level and async edge work clock stopped
// - I/O clock stops in deep sleep
// - Level wake needs two watchdog samples
// - Wake on samples or level persisting
// - Level gone at startup end: no interrupt
// - Two-bit sense: low, any, fall, rise
// - Async pin: zero falling, one rising
// - Flags set, cleared by ack/W1C, level clear
`timescale 1ns/100ps

`include "gpio_defs.svh"

module gpio_ports
  import gpio_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] pin_in,
  output pin_drive_t pin_drive,
  input wire logic io_clk_run,
  input wire logic deep_sleep,
  input wire logic startup_done,
  input wire logic [2:0] service_ack,
  output logic wake_req,
  output logic irq
);

  typedef struct packed {
    logic [31:0] out_data;
    logic [31:0] dir;
    logic [7:0] ctrl;
    logic [7:0] flags;
    logic [7:0] mask;
    logic prev_zero;
    logic prev_one;
    logic prev_async;
    logic [1:0] settle;
    logic [`WDT_CNT_W-1:0] wdt_cnt;
    logic [1:0] wake_samples;
    wake_state_t wake;
    logic aw_held;
    logic [`AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t q;
  state_t next_q;

  logic [31:0] pins;
  logic pin_zero;
  logic pin_one;
  logic pin_async;
  sense_t sense_zero;
  sense_t sense_one;
  logic async_rise;
  sense_t async_mode;
  logic [7:0] level_pending;
  logic [7:0] level_req;
  logic [7:0] set_ev;
  logic [7:0] clear_ev;
  logic [7:0] level_mode;
  logic wdt_strobe;
  logic edges_armed;
  logic [7:0] irq_sources;
  logic wr_fire;
  logic [32:0] rd_result;

  // Edge of the selected polarity between two consecutive synced samples
  function automatic logic edge_hit(input sense_t mode, input logic prev, input logic cur);
    logic hit;
    hit = 1'b0;
    unique case (mode)
      `SENSE_LOW: hit = 1'b0;
      `SENSE_ANY: hit = prev ^ cur;
      `SENSE_FALL: hit = prev & ~cur;
      `SENSE_RISE: hit = ~prev & cur;
    endcase
    return hit;
  endfunction

  // Returns {mapped, data}; unmapped offsets answer with zero data
  function automatic logic [32:0] reg_read(input logic [`AXI_ADDR_W-1:0] addr,
                                           input state_t s, input logic [31:0] lvl_pins,
                                           input logic [7:0] lvl);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (addr)
      `REG_PORT_A_OUT: r[7:0] = s.out_data[7:0];
      `REG_PORT_A_DIR: r[7:0] = s.dir[7:0];
      `REG_PORT_A_PINS: r[7:0] = lvl_pins[7:0];
      `REG_PORT_B_OUT: r[7:0] = s.out_data[15:8];
      `REG_PORT_B_DIR: r[7:0] = s.dir[15:8];
      `REG_PORT_B_PINS: r[7:0] = lvl_pins[15:8];
      `REG_PORT_C_OUT: r[7:0] = s.out_data[23:16];
      `REG_PORT_C_DIR: r[7:0] = s.dir[23:16];
      `REG_PORT_C_PINS: r[7:0] = lvl_pins[23:16];
      `REG_PORT_D_OUT: r[7:0] = s.out_data[31:24];
      `REG_PORT_D_DIR: r[7:0] = s.dir[31:24];
      `REG_PORT_D_PINS: r[7:0] = lvl_pins[31:24];
      `REG_CORE_CONTROL: r[7:0] = s.ctrl;
      `REG_IRQ_STATUS: r[7:0] = s.flags;
      `REG_IRQ_MASK: r[7:0] = s.mask;
      `REG_IRQ_LEVEL: begin
        r[7:0] = lvl;
        r[`WAKE_STATUS_BIT] = (s.wake == WAKE_STARTUP);
      end
      default: r = {1'b0, 32'h0000_0000};
    endcase
    return r;
  endfunction

  pin_sync u_pin_sync (
    .mclk(mclk),
    .rstn(rstn),
    .pin_in(pin_in),
    .pin_sync_out(pins)
  );

  // Pins are sensed whatever their direction, so writing an output can interrupt
  assign pin_zero = pins[`PIN_IRQ_ZERO];
  assign pin_one = pins[`PIN_IRQ_ONE];
  assign pin_async = pins[`PIN_IRQ_ASYNC];

  assign sense_zero = q.ctrl[`SENSE_ZERO_LSB +: 2];
  assign sense_one = q.ctrl[`SENSE_ONE_LSB +: 2];
  assign async_rise = q.ctrl[`ASYNC_SELECT_BIT];
  assign async_mode = async_rise ? `SENSE_RISE : `SENSE_FALL;

  // One write and one read in flight; a held item blocks its own channel
  assign s_axi_awready = !q.aw_held && !q.bvalid;
  assign s_axi_wready = !q.w_held && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // Pull-up on every input whose output bit is one
  assign pin_drive = {q.out_data, q.dir, q.out_data & ~q.dir};

  // Level requests are suppressed until wake-up completes; a level that drops
  // before startup_done therefore wakes the core but raises nothing.
  assign irq_sources = (q.flags | level_req) & q.mask;
  assign irq = |irq_sources;
  assign wake_req = (q.wake == WAKE_STARTUP);

  always_comb begin
    level_mode = 8'h00;
    level_mode[`FLAG_ZERO_BIT] = (sense_zero == `SENSE_LOW);
    level_mode[`FLAG_ONE_BIT] = (sense_one == `SENSE_LOW);
    // Low-level sensing needs no clock edge history, so it works in deep sleep
    level_pending = 8'h00;
    level_pending[`FLAG_ZERO_BIT] = level_mode[`FLAG_ZERO_BIT] && !pin_zero;
    level_pending[`FLAG_ONE_BIT] = level_mode[`FLAG_ONE_BIT] && !pin_one;
    level_pending = level_pending & q.mask;
    level_req = (q.wake == WAKE_AWAKE) ? level_pending : 8'h00;
  end

  always_comb begin
    set_ev = 8'h00;
    // Synced sample against previous sample; pulses over one clock are caught.
    // With the I/O clock halted these detectors see nothing.
    set_ev[`FLAG_ZERO_BIT] = io_clk_run && edge_hit(sense_zero, q.prev_zero, pin_zero);
    set_ev[`FLAG_ONE_BIT] = io_clk_run && edge_hit(sense_one, q.prev_one, pin_one);
    // The async pin keeps detecting in every sleep mode
    set_ev[`FLAG_ASYNC_BIT] = edge_hit(async_mode, q.prev_async, pin_async);
    set_ev = edges_armed ? set_ev : 8'h00;
  end

  // Synchroniser and previous-sample flops both start at zero, so a pin that
  // is high at reset would look like a rising edge until they have settled.
  assign edges_armed = (q.settle == `SYNC_SETTLE);
  // Watchdog tick stand-in; only level wake-up qualification uses it
  assign wdt_strobe = (q.wdt_cnt == `WDT_CNT_W'(`WDT_CYCLES - 1));
  // The answer follows one cycle after the later of address and data
  assign wr_fire = q.aw_held && q.w_held && !q.bvalid;
  assign rd_result = reg_read(s_axi_araddr, q, pins, level_pending);

  always_comb begin
    next_q = q;
    clear_ev = 8'h00;
    clear_ev[`FLAG_ZERO_BIT] = service_ack[0];
    clear_ev[`FLAG_ONE_BIT] = service_ack[1];
    clear_ev[`FLAG_ASYNC_BIT] = service_ack[2];

    next_q.prev_zero = pin_zero;
    next_q.prev_one = pin_one;
    next_q.prev_async = pin_async;
    // Counts the first cycles after reset and then holds
    next_q.settle = edges_armed ? q.settle : q.settle + 2'h1;

    // Write address and data are captured independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_q.aw_held = 1'b1;
      next_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_q.w_held = 1'b1;
      next_q.w_byte = s_axi_wdata[7:0];
      next_q.w_lane0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    if (wr_fire) begin
      next_q.aw_held = 1'b0;
      next_q.w_held = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = `RESP_OKAY;
      // Only byte lane 0 carries register bits; other lanes are dropped
      case (q.aw_addr)
        `REG_PORT_A_OUT: if (q.w_lane0) next_q.out_data[7:0] = q.w_byte;
        `REG_PORT_A_DIR: if (q.w_lane0) next_q.dir[7:0] = q.w_byte;
        `REG_PORT_B_OUT: if (q.w_lane0) next_q.out_data[15:8] = q.w_byte;
        `REG_PORT_B_DIR: if (q.w_lane0) next_q.dir[15:8] = q.w_byte;
        `REG_PORT_C_OUT: if (q.w_lane0) next_q.out_data[23:16] = q.w_byte;
        `REG_PORT_C_DIR: if (q.w_lane0) next_q.dir[23:16] = q.w_byte;
        `REG_PORT_D_OUT: if (q.w_lane0) next_q.out_data[31:24] = q.w_byte;
        `REG_PORT_D_DIR: if (q.w_lane0) next_q.dir[31:24] = q.w_byte;
        // Read-only views accept the write and drop it
        `REG_PORT_A_PINS, `REG_PORT_B_PINS, `REG_PORT_C_PINS, `REG_PORT_D_PINS,
        `REG_IRQ_LEVEL: begin
          next_q.bresp = `RESP_OKAY;
        end
        `REG_CORE_CONTROL: if (q.w_lane0) next_q.ctrl = q.w_byte & `CTRL_FIELD;
        `REG_IRQ_STATUS: if (q.w_lane0) clear_ev = clear_ev | q.w_byte;
        `REG_IRQ_MASK: if (q.w_lane0) next_q.mask = q.w_byte & `FLAG_FIELD;
        // Unmapped offsets store nothing
        default: next_q.bresp = `RESP_SLVERR;
      endcase
    end

    // A set in the same cycle as a clear wins; level mode holds the flag clear
    next_q.flags = ((q.flags & ~clear_ev) | set_ev) & `FLAG_FIELD & ~level_mode;

    // Read data is latched at the address handshake and held until taken
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = rd_result[31:0];
      next_q.rresp = rd_result[32] ? `RESP_OKAY : `RESP_SLVERR;
    end

    // Free-running stand-in for the watchdog oscillator period
    next_q.wdt_cnt = wdt_strobe ? '0 : q.wdt_cnt + `WDT_CNT_W'(1);

    unique case (q.wake)
      WAKE_AWAKE: begin
        // Sleep entry starts qualification with no samples counted
        next_q.wake_samples = 2'h0;
        if (deep_sleep) begin
          next_q.wake = WAKE_QUALIFY;
        end
      end
      WAKE_QUALIFY: begin
        // Noise guard: the low level must be seen on consecutive samples
        if (!deep_sleep) begin
          next_q.wake = WAKE_AWAKE;
        end else if (wdt_strobe) begin
          if (|level_pending) begin
            next_q.wake_samples = q.wake_samples + 2'h1;
            if (q.wake_samples == 2'(`WAKE_SAMPLES - 1)) begin
              next_q.wake = WAKE_STARTUP;
            end
          end else begin
            next_q.wake_samples = 2'h0;
          end
        end
      end
      WAKE_STARTUP: begin
        // Start-up length belongs to the core; only its end is seen here
        if (startup_done) begin
          next_q.wake = WAKE_AWAKE;
        end
      end
      default: begin
        // The spare code is no state; fall back to awake rather than hang
        next_q.wake = WAKE_AWAKE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.out_data <= {4{`OUT_RESET}};
      q.dir <= {4{`DIR_RESET}};
      q.ctrl <= `CTRL_RESET;
      q.flags <= `FLAG_RESET;
      q.mask <= `MASK_RESET;
      q.wake <= WAKE_AWAKE;
    end else begin
      q <= next_q;
    end
  end

endmodule

// *** testbench/gpio_ports_assertions.sv ***
/* Checker on the ports of gpio_ports: AXI answers, pin drive, wake exit.
   Assumes one clock mclk and the active-low reset rstn. */
`timescale 1ns/100ps
module gpio_ports_chk
  import gpio_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pin_drive_t pin_drive,
  input wire logic startup_done,
  input wire logic wake_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rd_stable_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper bits set");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while busy");
  pull_up_a: assert property (pin_drive.pull_up == (pin_drive.out & ~pin_drive.oe))
    else $error("pull-up mismatch");
  drive_reset_a: assert property ($rose(rstn) |-> pin_drive == '0)
    else $error("pin drive not cleared by reset");
  drive_write_a: assert property ($changed(pin_drive) |-> $rose(s_axi_bvalid))
    else $error("pin drive moved without a write");
  wake_end_a: assert property (wake_req && startup_done |=> !wake_req)
    else $error("wake request outlives start-up");
endmodule

bind gpio_ports gpio_ports_chk u_gpio_ports_chk (.mclk(mclk), .rstn(rstn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_drive(pin_drive), .startup_done(startup_done), .wake_req(wake_req));

// *** testbench/pin_partner.sv ***
/* External circuitry on the 32 pins: resolves block drive, outside drive,
   pull-ups and floating lines. Assumes pins are driven only where enabled. */
`timescale 1ns/100ps
module pin_partner
  import gpio_pkg::*;
(
  input wire logic mclk,
  input wire pin_drive_t pin_drive,
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  output logic [31:0] pin_in
);
  // A floating line must not keep its last level, so it flips every cycle
  logic [31:0] flt = '0;
  always_ff @(posedge mclk) begin
    flt <= ~pin_in;
  end
  // Pins read back their own drive, so outputs still reach the detectors
  assign pin_in = (pin_drive.oe & pin_drive.out) | (~pin_drive.oe &
    ((ext_en & ext_val) | (~ext_en & (pin_drive.pull_up | flt))));
endmodule

// *** testbench/test_gpio_ports.sv ***
/* Self-checking bench of gpio_ports: random port traffic, pin interrupts, wake.
   Assumes gpio_defs.svh, the checker bind and pin_partner. */
`timescale 1ns/100ps
`include "gpio_defs.svh"
module test_gpio_ports
  import gpio_pkg::*;
;
  logic mclk = 0, rstn = 0, io_run = 1, sleep = 0, st_done = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [2:0] ack = '0;
  logic [7:0] awaddr = '0, araddr = '0, o, dr, e, en;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] wdata = '0, ext_val = '1, ext_en = '1, pin_in, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, wake_req, irq, irq_s, wake_s;
  pin_drive_t pin_drive;
  int n_fail = 0, compares = 0, cyc = 0, n;

  initial forever #20 mclk = ~mclk;

  gpio_ports u_gpio_ports (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_in), .pin_drive(pin_drive), .io_clk_run(io_run), .deep_sleep(sleep),
    .startup_done(st_done), .service_ack(ack), .wake_req(wake_req), .irq(irq));
  pin_partner u_pin_partner (.mclk(mclk), .pin_drive(pin_drive), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  // Outputs are looked at away from the rising edge to keep clear of races
  always @(negedge mclk) begin
    irq_s = irq;
    wake_s = wake_req;
  end

  task automatic print_verdict;
    if (n_fail == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cy(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // Driven bits show the output; released bits the outside level or the pull-up
  function automatic logic [7:0] pin_exp(input logic [7:0] ov, dv, env, ev);
    return dv & ov | ~dv & (env & ev | ~env & ov);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 0);
    logic ta, tw, tb;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(negedge mclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid & bready;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      bready <= !tb && !awvalid && !wvalid;
    end while (!tb);
    chk("write response", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] ex, input string nm,
                    input logic [1:0] er = 0);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1;
    do begin
      @(negedge mclk);
      ta = arvalid & arready;
      tr = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 0;
      rready <= !tr && !arvalid;
    end while (!tr);
    chk(nm, d, ex);
    chk("read response", {30'h0, r}, {30'h0, er});
  endtask

  task automatic edge_chk(input int b, input logic v, input logic [31:0] ex);
    ext_val[b] <= v;
    cy(5);
    rc(`REG_IRQ_STATUS, ex, "flags");
    chk("irq", {31'h0, irq_s}, {31'h0, ex != 0});
    wr(`REG_IRQ_STATUS, 32'hE0);
  endtask

  initial begin
    void'($urandom(32'h1750C04D));
    repeat (20) @(posedge mclk);
    rstn <= 1;
    @(posedge mclk);
    for (int p = 0; p < 4; p++) begin
      rc(8'(p * 16), 0, "out reset");
      rc(8'(p * 16 + 4), 0, "dir reset");
    end
    for (int p = 0; p < 4; p++) begin
      o = 8'($urandom);
      dr = 8'($urandom);
      e = 8'($urandom);
      en = 8'($urandom) | ~o;
      wr(8'(p * 16), {24'($urandom), o});
      wr(8'(p * 16 + 4), {24'h0, dr});
      ext_val[p * 8 +: 8] <= e;
      ext_en[p * 8 +: 8] <= en;
      cy(4);
      rc(8'(p * 16), {24'h0, o}, "out data");
      rc(8'(p * 16 + 4), {24'h0, dr}, "direction");
      wstrb <= 4'hE;
      wr(8'(p * 16), {24'h0, ~o});
      wstrb <= 4'hF;
      rc(8'(p * 16), {24'h0, o}, "lane 0 off");
      wr(8'(p * 16 + 8), {24'h0, ~e});
      rc(8'(p * 16 + 8), {24'h0, pin_exp(o, dr, en, e)}, "pin levels");
      chk("pin out", {24'h0, pin_drive.out[p * 8 +: 8]}, {24'h0, o});
      chk("pin oe", {24'h0, pin_drive.oe[p * 8 +: 8]}, {24'h0, dr});
      wr(8'(p * 16 + 4), 0);
      ext_val[p * 8 +: 8] <= 8'hFF;
      ext_en[p * 8 +: 8] <= 8'hFF;
    end
    cy(4);
    wr(`REG_CORE_CONTROL, 32'hFF);
    rc(`REG_CORE_CONTROL, 32'h4F, "control");
    wr(`REG_IRQ_STATUS, 32'hE0);
    wr(8'h50, 0, `RESP_SLVERR);
    rc(8'h50, 0, "unmapped", `RESP_SLVERR);
    wr(`REG_IRQ_MASK, 32'hE0);
    rc(`REG_IRQ_STATUS, 0, "flags cleared");
    rc(`REG_IRQ_MASK, 32'hE0, "mask");
    for (int q = 0; q < 2; q++) begin
      for (int m = 1; m < 4; m++) begin
        wr(`REG_CORE_CONTROL, 32'(m << (2 * q)));
        wr(`REG_IRQ_STATUS, 32'hE0);
        edge_chk(26 + q, 0, 32'(m != 3) << (6 + q));
        edge_chk(26 + q, 1, 32'(m != 2) << (6 + q));
      end
    end
    io_run <= 0;
    wr(`REG_CORE_CONTROL, 32'h05);
    wr(`REG_IRQ_STATUS, 32'hE0);
    edge_chk(26, 0, 0);
    edge_chk(26, 1, 0);
    for (int s = 0; s < 2; s++) begin
      wr(`REG_CORE_CONTROL, 32'(s << 6));
      wr(`REG_IRQ_STATUS, 32'hE0);
      edge_chk(10, 0, s ? 0 : 32'h20);
      edge_chk(10, 1, s ? 32'h20 : 0);
    end
    io_run <= 1;
    wr(`REG_CORE_CONTROL, 32'h0C);
    wr(`REG_PORT_D_OUT, 0);
    wr(`REG_PORT_D_DIR, 32'h08);
    wr(`REG_IRQ_STATUS, 32'hE0);
    wr(`REG_PORT_D_OUT, 32'h08);
    cy(5);
    rc(`REG_IRQ_STATUS, 32'h80, "output flag");
    ack <= 3'h2;
    @(posedge mclk);
    ack <= 0;
    cy(1);
    rc(`REG_IRQ_STATUS, 0, "serviced flag");
    wr(`REG_PORT_D_DIR, 0);
    wr(`REG_CORE_CONTROL, 0);
    wr(`REG_IRQ_STATUS, 32'hE0);
    ext_val[26] <= 0;
    cy(5);
    rc(`REG_IRQ_STATUS, 0, "level flag");
    rc(`REG_IRQ_LEVEL, 32'h40, "level view");
    chk("level irq", {31'h0, irq_s}, 1);
    ext_val[26] <= 1;
    cy(5);
    chk("level irq off", {31'h0, irq_s}, 0);
    for (int k = 0; k < 2; k++) begin
      sleep <= 1;
      io_run <= 0;
      ext_val[26] <= 0;
      n = 0;
      while (!wake_s && n < 200) begin
        @(posedge mclk);
        n++;
      end
      chk("wake delay", 32'(n >= 24 && n <= 60), 1);
      chk("irq in wake", {31'h0, irq_s}, 0);
      if (k == 0) ext_val[26] <= 1;
      cy(4);
      sleep <= 0;
      io_run <= 1;
      st_done <= 1;
      @(posedge mclk);
      st_done <= 0;
      cy(3);
      chk("wake done", {31'h0, wake_s}, 0);
      chk("wake irq", {31'h0, irq_s}, 32'(k));
      ext_val[26] <= 1;
      cy(5);
    end
    print_verdict();
  end
endmodule
